// [verilog/rss_map.svh]
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// register indices, byte address is four times the index
`define RSS_IDX_DELAY_SELECT 6'h20
`define RSS_IDX_DELAY_EXT 6'h21
`define RSS_IDX_BUCK12 6'h22
`define RSS_IDX_BUCK34 6'h23
`define RSS_IDX_BACKUP 6'h24
`define RSS_IDX_SWLDO 6'h25
`define RSS_IDX_CONTROL 6'h30
`define RSS_IDX_UNLOCK 6'h31
`define RSS_IDX_STATUS 6'h32

// reset values and writable masks
`define RSS_RST_DELAY 8'h00
`define RSS_RST_BUCK12 8'h55
`define RSS_RST_BUCK34 8'h37
`define RSS_RST_BACKUP 8'h00
`define RSS_RST_SWLDO 8'hA8
`define RSS_MASK_BACKUP 8'h33
`define RSS_MASK_DELAY_EXT 8'h81

// field positions and unlock key
`define RSS_CTRL_START_UP 0
`define RSS_CTRL_START_DOWN 1
`define RSS_CTRL_SEAL 2
`define RSS_EXT_FACTOR 7
`define RSS_UNLOCK_KEY 8'h5A

// strobe numbers
`define RSS_STROBE_FIRST 4'h1
`define RSS_STROBE_LAST_BACKUP 4'h2
`define RSS_STROBE_FIRST_MAIN 4'h3
`define RSS_STROBE_LAST 4'hA

// timing
`define RSS_CLK_MHZ 100
`define RSS_DELAY_SHORT_MS 2
`define RSS_DELAY_LONG_MS 5
`define RSS_DOWN_FACTOR 10

`endif

// [verilog/rss_pkg.sv]
package rss_pkg;

    typedef enum logic [1:0]
    {
        RSS_IDLE = 2'b00,
        RSS_STROBE = 2'b01,
        RSS_WAIT = 2'b10
    } rss_state_type;

    typedef logic [3:0] rss_strobe_type;

endpackage : rss_pkg

// [verilog/rss_delay_timer.sv]
module rss_delay_timer
    import rss_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);

    logic [WIDTH-1:0] remain;

    // ----------------------------------------
    // countdown, done pulses count cycles after load
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remain <= '0;
        end
        else if (load)
        begin
            remain <= count;
        end
        else if (remain != '0)
        begin
            remain <= remain - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= !load && (remain == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

endmodule : rss_delay_timer

// [verilog/rss_rail_strobe_top.sv]
// The APB interface to the registers is this design's own decision.
`include "rss_map.svh"

module rss_rail_strobe_top
    import rss_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = `RSS_DELAY_SHORT_MS * 1000 * `RSS_CLK_MHZ,
    parameter int unsigned LONG_CYCLES = `RSS_DELAY_LONG_MS * 1000 * `RSS_CLK_MHZ,
    parameter int unsigned RAILS = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [RAILS-1:0] rail_enable,
    output logic seq_busy
);

    logic [7:0] strobe_delay_select;
    logic [7:0] strobe_delay_ext;
    logic [7:0] buck_one_two_strobe;
    logic [7:0] buck_three_four_strobe;
    logic [7:0] backup_buck_strobe;
    logic [7:0] switch_ldo_strobe;
    logic freshness_seal_flag;
    logic unlock_armed;
    logic powered;
    rss_state_type state;
    rss_strobe_type strobe;
    logic dir_up;
    logic wr_en;
    logic prot_wr;
    logic start_up;
    logic start_down;
    logic [5:0] idx;
    logic [31:0] next_rdata;
    logic next_err;
    logic [3:0] rail_code [RAILS];
    logic [RAILS-1:0] match;
    logic [RAILS-1:0] keep_mask;
    logic [8:0] dly_bits;
    logic dly_bit;
    logic last_strobe;
    rss_strobe_type first_strobe;
    logic t_load;
    logic [31:0] t_count;
    logic t_done;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign idx = paddr[7:2];
    assign wr_en = psel && penable && pwrite;
    assign prot_wr = wr_en && unlock_armed;
    assign pready = 1'b1;
    assign start_up = wr_en && (idx == `RSS_IDX_CONTROL) && pwdata[`RSS_CTRL_START_UP];
    assign start_down = wr_en && (idx == `RSS_IDX_CONTROL) && pwdata[`RSS_CTRL_START_DOWN];
    assign seq_busy = (state != RSS_IDLE);

    always_comb
    begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (idx)
            `RSS_IDX_DELAY_SELECT: next_rdata[7:0] = strobe_delay_select;
            `RSS_IDX_DELAY_EXT: next_rdata[7:0] = strobe_delay_ext;
            `RSS_IDX_BUCK12: next_rdata[7:0] = buck_one_two_strobe;
            `RSS_IDX_BUCK34: next_rdata[7:0] = buck_three_four_strobe;
            `RSS_IDX_BACKUP: next_rdata[7:0] = backup_buck_strobe;
            `RSS_IDX_SWLDO: next_rdata[7:0] = switch_ldo_strobe;
            `RSS_IDX_CONTROL: next_rdata[`RSS_CTRL_SEAL] = freshness_seal_flag;
            `RSS_IDX_UNLOCK: next_rdata[0] = unlock_armed;
            `RSS_IDX_STATUS: next_rdata[15:0] = {rail_enable, freshness_seal_flag,
                unlock_armed, powered, seq_busy, strobe};
            default: next_err = 1'b1;
        endcase
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= next_err;
        end
        else
        begin
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // protected assignment and delay registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_delay_select <= `RSS_RST_DELAY;
            strobe_delay_ext <= `RSS_RST_DELAY;
            buck_one_two_strobe <= `RSS_RST_BUCK12;
            buck_three_four_strobe <= `RSS_RST_BUCK34;
            backup_buck_strobe <= `RSS_RST_BACKUP;
            switch_ldo_strobe <= `RSS_RST_SWLDO;
        end
        else if (prot_wr)
        begin
            case (idx)
                `RSS_IDX_DELAY_SELECT: strobe_delay_select <= pwdata[7:0];
                `RSS_IDX_DELAY_EXT: strobe_delay_ext <= pwdata[7:0] & `RSS_MASK_DELAY_EXT;
                `RSS_IDX_BUCK12: buck_one_two_strobe <= pwdata[7:0];
                `RSS_IDX_BUCK34: buck_three_four_strobe <= pwdata[7:0];
                `RSS_IDX_BACKUP: backup_buck_strobe <= pwdata[7:0] & `RSS_MASK_BACKUP;
                `RSS_IDX_SWLDO: switch_ldo_strobe <= pwdata[7:0];
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // unlock and seal
    // ----------------------------------------
    // key arms exactly one following write; any other write disarms
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unlock_armed <= 1'b0;
        end
        else if (wr_en)
        begin
            unlock_armed <= (idx == `RSS_IDX_UNLOCK) && (pwdata[7:0] == `RSS_UNLOCK_KEY);
        end
    end

    // once set the seal stays set until reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            freshness_seal_flag <= 1'b0;
        end
        else if (wr_en && (idx == `RSS_IDX_CONTROL) && pwdata[`RSS_CTRL_SEAL])
        begin
            freshness_seal_flag <= 1'b1;
        end
    end

    // ----------------------------------------
    // strobe matching per rail
    // ----------------------------------------
    assign rail_code[0] = buck_one_two_strobe[3:0];
    assign rail_code[1] = buck_one_two_strobe[7:4];
    assign rail_code[2] = buck_three_four_strobe[3:0];
    assign rail_code[3] = buck_three_four_strobe[7:4];
    assign rail_code[4] = {2'b00, backup_buck_strobe[1:0]};
    assign rail_code[5] = {2'b00, backup_buck_strobe[5:4]};
    assign rail_code[6] = switch_ldo_strobe[3:0];
    assign rail_code[7] = switch_ldo_strobe[7:4];

    generate
        for (genvar i = 0; i < RAILS; i++)
        begin : g_match
            if (i == 4 || i == 5)
            begin : g_backup
                assign match[i] = (rail_code[i] == strobe)
                    && (strobe <= `RSS_STROBE_LAST_BACKUP) && !freshness_seal_flag;
                assign keep_mask[i] = !freshness_seal_flag;
            end
            else
            begin : g_main
                assign match[i] = (rail_code[i] == strobe)
                    && (strobe >= `RSS_STROBE_FIRST_MAIN) && (strobe <= `RSS_STROBE_LAST);
                assign keep_mask[i] = 1'b1;
            end
        end
    endgenerate

    // ----------------------------------------
    // inter-strobe delay selection
    // ----------------------------------------
    assign dly_bits = {strobe_delay_ext[0], strobe_delay_select};
    assign first_strobe = freshness_seal_flag ? `RSS_STROBE_FIRST_MAIN : `RSS_STROBE_FIRST;
    assign last_strobe = dir_up ? (strobe == `RSS_STROBE_LAST) : (strobe == first_strobe);

    always_comb
    begin
        dly_bit = 1'b0;
        if (dir_up)
        begin
            dly_bit = dly_bits[strobe - 4'h1];
        end
        else if (strobe >= 4'h2)
        begin
            dly_bit = dly_bits[strobe - 4'h2];
        end
    end

    always_comb
    begin
        t_load = (state == RSS_STROBE) && !last_strobe;
        t_count = dly_bit ? LONG_CYCLES : SHORT_CYCLES;
        if (!dir_up && strobe_delay_ext[`RSS_EXT_FACTOR])
        begin
            t_count = 32'(t_count * `RSS_DOWN_FACTOR);
        end
    end

    rss_delay_timer #(
        .WIDTH(32)
    ) rss_delay_timer_inst (
        .pclk(pclk),
        .presetn(presetn),
        .load(t_load),
        .count(t_count),
        .done(t_done)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= RSS_IDLE;
            strobe <= `RSS_STROBE_FIRST;
            dir_up <= 1'b1;
        end
        else
        begin
            case (state)
                RSS_IDLE:
                begin
                    if (start_up)
                    begin
                        dir_up <= 1'b1;
                        strobe <= first_strobe;
                        state <= RSS_STROBE;
                    end
                    else if (start_down)
                    begin
                        dir_up <= 1'b0;
                        strobe <= `RSS_STROBE_LAST;
                        state <= RSS_STROBE;
                    end
                end
                RSS_STROBE:
                begin
                    state <= last_strobe ? RSS_IDLE : RSS_WAIT;
                end
                RSS_WAIT:
                begin
                    if (t_done)
                    begin
                        strobe <= dir_up ? strobe + 4'h1 : strobe - 4'h1;
                        state <= RSS_STROBE;
                    end
                end
                default:
                begin
                    state <= RSS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rail_enable <= '0;
        end
        else if (state == RSS_STROBE)
        begin
            if (dir_up)
            begin
                rail_enable <= rail_enable | match;
            end
            else
            begin
                rail_enable <= rail_enable & ~(match & keep_mask);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            powered <= 1'b0;
        end
        else if (state == RSS_IDLE && start_down)
        begin
            powered <= 1'b0;
        end
        else if (state == RSS_STROBE && dir_up && last_strobe)
        begin
            powered <= 1'b1;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    locked_write_a : assert property (
        wr_en && !unlock_armed && idx == `RSS_IDX_BUCK12
        |=> $stable(buck_one_two_strobe))
        else $error("assignment register changed without unlock");

    backup_reserved_a : assert property (
        (backup_buck_strobe & ~`RSS_MASK_BACKUP) == 8'h00)
        else $error("reserved backup bits not zero");

    main_enable_a : assert property (
        state == RSS_STROBE && dir_up && strobe == rail_code[0]
        && strobe >= `RSS_STROBE_FIRST_MAIN |=> rail_enable[0])
        else $error("buck1 not enabled at its strobe");

    outside_control_a : assert property (
        state == RSS_STROBE && (rail_code[1] < `RSS_STROBE_FIRST_MAIN
        || rail_code[1] > `RSS_STROBE_LAST) |=> $stable(rail_enable[1]))
        else $error("uncontrolled buck2 changed");

    backup_enable_a : assert property (
        state == RSS_STROBE && dir_up && !freshness_seal_flag
        && strobe <= `RSS_STROBE_LAST_BACKUP
        && rail_code[4] == strobe |=> rail_enable[4])
        else $error("backup rail not enabled at its strobe");

    sealed_skip_a : assert property (
        state == RSS_STROBE && freshness_seal_flag |-> strobe >= `RSS_STROBE_FIRST_MAIN)
        else $error("backup strobe ran while sealed");

    backup_hold_a : assert property (
        freshness_seal_flag && rail_enable[5] |=> rail_enable[5])
        else $error("sealed backup rail disabled");

    delay_figure_a : assert property (
        t_load && dir_up |-> t_count == (dly_bits[strobe - 4'h1] ? LONG_CYCLES : SHORT_CYCLES))
        else $error("wrong inter-strobe delay");

    down_factor_a : assert property (
        t_load && !dir_up && strobe_delay_ext[`RSS_EXT_FACTOR]
        |-> t_count == 32'((dly_bits[strobe - 4'h2] ? LONG_CYCLES : SHORT_CYCLES)
        * `RSS_DOWN_FACTOR))
        else $error("power-down delay not scaled");

    ascending_step_a : assert property (
        state == RSS_WAIT && dir_up && t_done
        |=> state == RSS_STROBE && strobe == $past(strobe) + 4'h1)
        else $error("power-up strobe did not advance by one");

endmodule : rss_rail_strobe_top

// [sim/tb_rss_rail_strobe_top.sv]
module tb_rss_rail_strobe_top
    import rss_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // signals and settings
    // ----------------------------------------------------------------
    localparam int SHORT = 20;
    localparam int LONG = 50;
    localparam int GAP = SHORT + 2;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] rail_enable;
    logic seq_busy;
    logic [31:0] rd;
    logic err;
    int t[8];
    int fails = 0;
    int checked = 0;

    rss_rail_strobe_top #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG), .RAILS(8))
        rss_rail_strobe_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rail_enable(rail_enable), .seq_busy(seq_busy));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        n = 0;
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                fails++;
                give_verdict();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // arms the unlock right before the protected write
    task automatic wprot(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, 8'hC4, 32'h0000005A);
        apb(1'b1, a, d);
    endtask : wprot

    // starts a sequence and records, per rail, the edge count of its first change
    task automatic run_seq(input logic [31:0] cmd);
        logic [7:0] start;
        int n;
        apb(1'b1, 8'hC0, cmd);
        #1;
        start = rail_enable;
        t = '{default: -1};
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
            for (int b = 0; b < 8; b++)
                if (t[b] < 0 && rail_enable[b] !== start[b])
                    t[b] = n;
            if (n > 3000)
            begin
                fails++;
                give_verdict();
            end
        end
        while (n < 2 || seq_busy !== 1'b0);
    endtask : run_seq

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_values();
        apb(1'b0, 8'h88, 32'h0);
        check("buck_one_two_strobe", rd, 32'h55);
        apb(1'b0, 8'h8C, 32'h0);
        check("buck_three_four_strobe", rd, 32'h37);
        apb(1'b0, 8'h90, 32'h0);
        check("backup_buck_strobe", rd, 32'h00);
        apb(1'b0, 8'h94, 32'h0);
        check("switch_ldo_strobe", rd, 32'hA8);
        wprot(8'h90, 32'hFF);
        apb(1'b0, 8'h90, 32'h0);
        check("backup_buck_strobe reserved", rd, 32'h33);
        apb(1'b0, 8'hFC, 32'h0);
        check("unmapped error", err, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask : test_reset_values

    task automatic test_unlock();
        apb(1'b1, 8'h8C, 32'h11);
        apb(1'b0, 8'h8C, 32'h0);
        check("locked write", rd, 32'h37);
        apb(1'b1, 8'hC4, 32'h5A);
        apb(1'b1, 8'hC0, 32'h0);
        apb(1'b1, 8'h88, 32'h99);
        apb(1'b0, 8'h88, 32'h0);
        check("disarmed write", rd, 32'h55);
        wprot(8'h88, 32'h99);
        apb(1'b0, 8'h88, 32'h0);
        check("unlocked write", rd, 32'h99);
    endtask : test_unlock

    task automatic test_code_table();
        int e0;
        int e4;
        for (int c = 0; c < 16; c++)
        begin
            do_reset();
            wprot(8'h88, c);
            wprot(8'h90, c % 4);
            run_seq(32'h1);
            e0 = (c >= 3 && c <= 10) ? 1 + (c - 1) * GAP : -1;
            e4 = (c % 4 == 1 || c % 4 == 2) ? 1 + (c % 4 - 1) * GAP : -1;
            check("buck1 enable time", t[0], e0);
            check("buck2 uncontrolled", t[1], -1);
            check("backup a enable time", t[4], e4);
        end
    endtask : test_code_table

    task automatic test_timing_seal();
        do_reset();
        wprot(8'h80, 32'h01);
        wprot(8'h84, 32'hFF);
        apb(1'b0, 8'h84, 32'h0);
        check("delay extension bits", rd, 32'h81);
        wprot(8'h88, 32'h03);
        wprot(8'h90, 32'h21);
        run_seq(32'h1);
        check("strobe 1 time", t[4], 1);
        check("long gap", t[5], 1 + LONG + 2);
        check("factor ignored on power-up", t[0], 1 + LONG + 2 + GAP);
        apb(1'b0, 8'hC8, 32'h0);
        check("status after power-up", rd, 32'h0000FD2A);
        apb(1'b1, 8'hC0, 32'h04);
        run_seq(32'h2);
        check("power-down gaps", t[0], 1 + (LONG * 10 + 2) + 6 * (SHORT * 10 + 2));
        check("backup rails kept", rail_enable[5:4], 2'b11);
        do_reset();
        apb(1'b1, 8'hC0, 32'h04);
        wprot(8'h88, 32'h03);
        wprot(8'h90, 32'h21);
        run_seq(32'h1);
        check("sealed first strobe", t[0], 1);
        check("sealed backup rails", rail_enable[5:4], 2'b00);
    endtask : test_timing_seal

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        do_reset();
        test_reset_values();
        test_unlock();
        test_code_table();
        test_timing_seal();
        give_verdict();
    end

endmodule : tb_rss_rail_strobe_top
